// ---- rtl/adc_demux_pkg.sv ----
// Purpose: Shared constants, types and register map of the ADC output demux block
// Assumes: 32-bit APB, one aligned word per register
// Notes: Codes are 8-bit offset binary
package adc_demux_pkg;

  localparam int CODE_W = 8;
  localparam int APB_DW = 32;

  // Output modes
  typedef enum logic [1:0] {
    full_rate_single_port_mode = 2'b00,
    half_rate_demux_mode = 2'b01,
    quarter_rate_decimation_mode = 2'b10
  } demux_mode_e;

  // One converted sample with its overrange bit
  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic overrange;
  } sample_s;

  // Code points
  localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
  localparam logic [CODE_W-1:0] CODE_FULL = 8'hFF;
  localparam logic [CODE_W-1:0] CODE_MID_HI = 8'h80;
  localparam logic [CODE_W-1:0] CODE_MID_LO = 8'h7F;
  localparam logic signed [CODE_W:0] DIFF_POS_FS = 9'sh080;
  localparam logic signed [CODE_W:0] DIFF_NEG_FS = -9'sh080;

  // Phase counter
  localparam logic [1:0] PHASE_RST = 2'h0;
  localparam logic [1:0] PHASE_HALF_RATE_DEMUX_MODE_MASK = 2'h1;
  localparam logic [1:0] PHASE_QUARTER_RATE_DECIMATION_MODE_MASK = 2'h3;
  localparam logic [1:0] PHASE_HALF_RATE_DEMUX_MODE_UPD = 2'h1;
  localparam logic [1:0] PHASE_QUARTER_RATE_DECIMATION_MODE_UPD = 2'h2;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0C;

  // Field positions
  localparam int CTRL_RESYNC_BIT = 0;
  localparam int EVT_OVR_BIT = 0;
  localparam int EVT_MODE_BIT = 1;
  localparam int EVT_W = 2;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_PHASE_LSB = 2;
  localparam int ST_AUXPWR_BIT = 4;
  localparam int ST_OVR_BIT = 5;

  localparam logic [EVT_W-1:0] EVT_RST = 2'h0;
  localparam logic [APB_DW-1:0] WORD_ZERO = 32'h0000_0000;

endpackage : adc_demux_pkg

// ---- rtl/adc_code_encoder.sv ----
// Purpose: Quantise the differential input into an offset binary sample
// Assumes: Inputs are signed levels in LSB units, sampled each rising ref_clk_in edge
// Notes: Zero difference alternates between the two midscale codes
`timescale 1ns/10ps
module adc_code_encoder
  import adc_demux_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic signed [CODE_W-1:0] analog_input_true_in,
  input wire logic signed [CODE_W-1:0] analog_input_complement_in,
  output sample_s sample_out
);

  logic signed [CODE_W:0] diff;
  logic mid_toggle;
  sample_s next_sample;

  // Differential level in LSB, both sides sign extended first so no carry is lost
  assign diff = (CODE_W+1)'(analog_input_true_in) - (CODE_W+1)'(analog_input_complement_in);

  // Offset binary with saturation at both ends
  always_comb
  begin
    next_sample.overrange = 1'b0;
    if (diff >= DIFF_POS_FS)
    begin
      next_sample.code = CODE_FULL;
      next_sample.overrange = 1'b1;
    end
    else if (diff <= DIFF_NEG_FS)
    begin
      next_sample.code = CODE_ZERO;
    end
    else if (diff == 9'sh000)
    begin
      next_sample.code = mid_toggle ? CODE_MID_LO : CODE_MID_HI;
    end
    else
    begin
      next_sample.code = CODE_W'(diff + DIFF_POS_FS);
    end
  end

  // Midscale alternation
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      mid_toggle <= 1'b0;
    else if (ce_in && diff == 9'sh000)
      mid_toggle <= ~mid_toggle;
  end

  // Sample register, one per rising clock edge
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      sample_out <= '0;
    else if (ce_in)
      sample_out <= next_sample;
  end

endmodule : adc_code_encoder

// ---- rtl/adc_output_demux.sv ----
// Purpose: Output demux, data-ready clock and overrange flag of an 8-bit flash ADC
// Assumes: ref_clk_in is the sampling clock; APB register access
// Notes: Second port outputs go all-high on both lines when powered down
// Operation
// - Demux enable low forces full-rate single-port mode, ignoring division select.
// - With demux enabled, division select low picks half rate, high quarter rate.
// - Full rate: sample on first port, repeated on second port one cycle later.
// - Second port powered down drives true and complement lines high.
// - Half rate: two consecutive samples together, older on second port.
// - Demux modes: outputs change only at data-ready rising edge; full rate changes them at both edges.
// - Quarter rate drops every second sample, retained ones split over ports.
// - One shared overrange flag; demux modes flag either port overranged.
// - Full rate flags overrange from first port only.
// - Zero differential input gives midscale code alternating 7F and 80.
// - Negative full scale gives 00 clear; positive gives FF with flag set.
// - Every sample is 8-bit offset binary on differential lines.
// - Samples taken on rising sampling clock edge, which times the demux.
// - Data-ready phase is arbitrary until a demux resync fixes it.
`timescale 1ns/10ps
module adc_output_demux
  import adc_demux_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic signed [CODE_W-1:0] analog_input_true_in,
  input wire logic signed [CODE_W-1:0] analog_input_complement_in,
  input wire logic demux_enable_in,
  input wire logic division_select_in,
  input wire logic second_port_power_a_in,
  input wire logic second_port_power_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [APB_DW-1:0] pwdata_in,
  output logic [APB_DW-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [CODE_W-1:0] first_port_data_out,
  output logic [CODE_W-1:0] first_port_data_n_out,
  output logic [CODE_W-1:0] second_port_data_out,
  output logic [CODE_W-1:0] second_port_data_n_out,
  output logic data_ready_out,
  output logic data_ready_n_out,
  output logic overrange_out,
  output logic overrange_n_out,
  output logic irq_out
);

  // Elaboration checks
  if (CODE_W != 8)
    $error("code width must be 8");
  if (ADDR_W < 4)
    $error("address width too small for register map");

  sample_s sample;
  demux_mode_e mode;
  demux_mode_e mode_q;
  logic [1:0] phase;
  logic [1:0] phase_mask;
  logic update;
  logic keep_older;
  sample_s held;
  sample_s first;
  sample_s second;
  logic flag;
  logic dready;
  logic aux_powered;
  logic resync;
  logic [EVT_W-1:0] status;
  logic [EVT_W-1:0] mask;
  logic [EVT_W-1:0] events;
  logic flag_q;
  logic apb_setup;
  logic apb_write;
  logic [7:0] addr8;
  logic mapped;
  logic [APB_DW-1:0] next_rdata;

  adc_code_encoder u_encoder (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .analog_input_true_in(analog_input_true_in),
    .analog_input_complement_in(analog_input_complement_in),
    .sample_out(sample)
  );

  // Mode decode from the two select pins
  always_comb
  begin
    if (!demux_enable_in)
      mode = full_rate_single_port_mode;
    else if (!division_select_in)
      mode = half_rate_demux_mode;
    else
      mode = quarter_rate_decimation_mode;
  end

  // Phase position and update points per mode
  always_comb
  begin
    case (mode)
      half_rate_demux_mode:
      begin
        phase_mask = PHASE_HALF_RATE_DEMUX_MODE_MASK;
        update = (phase == PHASE_HALF_RATE_DEMUX_MODE_UPD);
        keep_older = (phase == PHASE_RST);
      end
      quarter_rate_decimation_mode:
      begin
        phase_mask = PHASE_QUARTER_RATE_DECIMATION_MODE_MASK;
        update = (phase == PHASE_QUARTER_RATE_DECIMATION_MODE_UPD);
        keep_older = (phase == PHASE_RST);
      end
      default:
      begin
        phase_mask = PHASE_RST;
        update = 1'b1;
        keep_older = 1'b0;
      end
    endcase
  end

  // Divider phase, realigned by a demux resync
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      phase <= PHASE_RST;
    else if (ce_in)
    begin
      if (resync)
        phase <= PHASE_RST;
      else
        phase <= (phase + 2'h1) & phase_mask;
    end
  end

  // Older sample store for the demux modes
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      held <= '0;
    else if (ce_in && keep_older)
      held <= sample;
  end

  // Port registers, changing only at an update
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      first <= '0;
      second <= '0;
    end
    else if (ce_in && update)
    begin
      first <= sample;
      if (mode == full_rate_single_port_mode)
        second <= first;
      else
        second <= held;
    end
  end

  // Shared overrange flag follows the mode
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      flag <= 1'b0;
    else if (ce_in && update)
    begin
      if (mode == full_rate_single_port_mode)
        flag <= sample.overrange;
      else
        flag <= sample.overrange | held.overrange;
    end
  end

  // Data-ready clock rises with each update in the demux modes, toggles every sample in full rate
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      dready <= 1'b0;
    else if (ce_in)
    begin
      if (mode == full_rate_single_port_mode)
        dready <= ~dready;
      else if (update)
        dready <= 1'b1;
      else if (phase == PHASE_RST)
        dready <= 1'b0;
    end
  end

  assign aux_powered = second_port_power_a_in & second_port_power_b_in;

  // Differential output pairs
  genvar gi;
  for (gi = 0; gi < CODE_W; gi++)
  begin : g_bits
    assign first_port_data_out[gi] = first.code[gi];
    assign first_port_data_n_out[gi] = ~first.code[gi];
    assign second_port_data_out[gi] = aux_powered ? second.code[gi] : 1'b1;
    assign second_port_data_n_out[gi] = aux_powered ? ~second.code[gi] : 1'b1;
  end

  assign data_ready_out = dready;
  assign data_ready_n_out = ~dready;
  assign overrange_out = flag;
  assign overrange_n_out = ~flag;

  // APB decode
  assign apb_setup = psel_in & ~penable_in;
  assign apb_write = psel_in & penable_in & pwrite_in;
  assign addr8 = 8'(paddr_in);
  assign pready_out = psel_in & penable_in;

  always_comb
  begin
    mapped = 1'b1;
    next_rdata = WORD_ZERO;
    if (addr8 == OFS_CTRL)
      next_rdata = WORD_ZERO;
    else if (addr8 == OFS_STATUS)
      next_rdata[EVT_W-1:0] = status;
    else if (addr8 == OFS_MASK)
      next_rdata[EVT_W-1:0] = mask;
    else if (addr8 == OFS_STATE)
    begin
      next_rdata[ST_MODE_LSB +: 2] = mode;
      next_rdata[ST_PHASE_LSB +: 2] = phase;
      next_rdata[ST_AUXPWR_BIT] = aux_powered;
      next_rdata[ST_OVR_BIT] = flag;
    end
    else
      mapped = 1'b0;
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      prdata_out <= WORD_ZERO;
      pslverr_out <= 1'b0;
    end
    else if (apb_setup)
    begin
      prdata_out <= pwrite_in ? WORD_ZERO : next_rdata;
      pslverr_out <= ~mapped;
    end
  end

  // Resync pulse from a control write
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      resync <= 1'b0;
    else if (apb_write && addr8 == OFS_CTRL)
      resync <= pwdata_in[CTRL_RESYNC_BIT];
    else if (ce_in)
      resync <= 1'b0;
  end

  // Mask register
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      mask <= EVT_RST;
    else if (apb_write && addr8 == OFS_MASK)
      mask <= pwdata_in[EVT_W-1:0];
  end

  // Events: new overrange and mode change
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      flag_q <= 1'b0;
      mode_q <= full_rate_single_port_mode;
    end
    else if (ce_in)
    begin
      flag_q <= flag;
      mode_q <= mode;
    end
  end

  always_comb
  begin
    events = EVT_RST;
    events[EVT_OVR_BIT] = ce_in & flag & ~flag_q;
    events[EVT_MODE_BIT] = ce_in & (mode != mode_q);
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      status <= EVT_RST;
    else if (apb_write && addr8 == OFS_STATUS)
      status <= (status & ~pwdata_in[EVT_W-1:0]) | events;
    else
      status <= status | events;
  end

  assign irq_out = |(status & mask);

  // Checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_mode_full_rate: assert property (!demux_enable_in |-> mode == full_rate_single_port_mode)
    else $error("demux disabled but not full rate");
  a_mode_select: assert property (demux_enable_in
    |-> (mode == quarter_rate_decimation_mode) == division_select_in)
    else $error("division select mismatch");
  a_full_repeat: assert property (ce_in && update && mode == full_rate_single_port_mode
    |=> second == $past(first))
    else $error("second port not one sample behind");
  a_aux_powerdown: assert property (!aux_powered |-> &second_port_data_out
    && &second_port_data_n_out)
    else $error("powered down second port not high");
  a_half_order: assert property (ce_in && mode == half_rate_demux_mode && phase == PHASE_RST
    ##1 ce_in && mode == half_rate_demux_mode && update && !resync
    |=> second == $past(sample, 2) && first == $past(sample))
    else $error("half rate order wrong");
  a_ports_stable: assert property (!(ce_in && update) |=> $stable(first) && $stable(second))
    else $error("ports changed outside update");
  a_quarter_rate: assert property (ce_in && mode == quarter_rate_decimation_mode && update
    |=> (!update || mode != quarter_rate_decimation_mode) [*3])
    else $error("quarter rate update not every fourth cycle");
  a_ovr_either: assert property (ce_in && update && mode != full_rate_single_port_mode
    |=> flag == (first.overrange | $past(held.overrange)))
    else $error("shared overrange wrong");
  a_ovr_first: assert property (ce_in && update && mode == full_rate_single_port_mode
    |=> flag == first.overrange)
    else $error("full rate overrange not from first port");
  a_full_scale: assert property (sample.overrange |-> sample.code == CODE_FULL)
    else $error("overrange without full scale code");
  a_resync_phase: assert property (ce_in && resync |=> phase == PHASE_RST)
    else $error("resync did not realign phase");
  a_quarter_order: assert property (ce_in && mode == quarter_rate_decimation_mode
    && phase == PHASE_RST && !resync ##2 ce_in && update && mode == quarter_rate_decimation_mode
    |=> second == $past(sample, 3))
    else $error("quarter rate order wrong");

  c_half_update: cover property (mode == half_rate_demux_mode && ce_in && update);
  c_quarter_update: cover property (mode == quarter_rate_decimation_mode && ce_in && update);
  c_overrange_irq: cover property (flag && irq_out);
  c_resync: cover property (ce_in && resync);

endmodule : adc_output_demux

// ---- sim/port_capture_model.sv ----
// Purpose: Downstream logic that latches both output ports
// Assumes: Latches at the clock edge after each data-ready rise
// Notes: Keeps the last pair and counts captures
`timescale 1ns/10ps
module port_capture_model
  import adc_demux_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [CODE_W-1:0] first_port_data_in,
  input wire logic [CODE_W-1:0] second_port_data_in,
  input wire logic data_ready_in,
  input wire logic overrange_in,
  output sample_s first_cap_out,
  output sample_s second_cap_out,
  output logic [15:0] cap_count_out
);
  logic ready_q;

  // Edge detect on data ready
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      ready_q <= 1'b0;
    else
      ready_q <= data_ready_in;
  end

  // Latch both ports once per data-ready rise
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      first_cap_out <= '0;
      second_cap_out <= '0;
      cap_count_out <= 16'h0000;
    end
    else if (data_ready_in && !ready_q)
    begin
      first_cap_out <= '{code: first_port_data_in, overrange: overrange_in};
      second_cap_out <= '{code: second_port_data_in, overrange: overrange_in};
      cap_count_out <= cap_count_out + 16'h0001;
    end
  end
endmodule : port_capture_model

// ---- sim/adc_output_demux_tb_top.sv ----
// Purpose: Self-checking bench for the ADC output demux block
// Assumes: Zero-wait APB and the stated pipeline latencies
// Notes: Inputs change at rising edges by non-blocking assignment
`timescale 1ns/10ps
module adc_output_demux_tb_top
  import adc_demux_pkg::*;
;
  logic clk, rst_n, ce, en, sel, pa, pb, psel, pen, pwr, ramp_on, inj;
  logic signed [CODE_W-1:0] vt, vc, ramp, dt, dc;
  logic [7:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata, rd;
  logic pready, pslverr, err, dr, dr_n, ovr, ovr_n, irq;
  logic [CODE_W-1:0] p1, p1_n, p2, p2_n, a;
  sample_s cf, cs;
  logic [15:0] ncap, n0;
  int fails, checked, cyc, hits;

  adc_output_demux dut (.ref_clk_in(clk), .resetn_in(rst_n), .ce_in(ce),
    .analog_input_true_in(vt), .analog_input_complement_in(vc),
    .demux_enable_in(en), .division_select_in(sel),
    .second_port_power_a_in(pa), .second_port_power_b_in(pb),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .first_port_data_out(p1), .first_port_data_n_out(p1_n),
    .second_port_data_out(p2), .second_port_data_n_out(p2_n),
    .data_ready_out(dr), .data_ready_n_out(dr_n), .overrange_out(ovr),
    .overrange_n_out(ovr_n), .irq_out(irq));

  port_capture_model capture (.ref_clk_in(clk), .resetn_in(rst_n),
    .first_port_data_in(p1), .second_port_data_in(p2), .data_ready_in(dr),
    .overrange_in(ovr), .first_cap_out(cf), .second_cap_out(cs), .cap_count_out(ncap));

  // Sampling clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Input source: held level, or a ramp stepping once per sample with optional overrange
  always @(posedge clk)
  begin
    ramp <= ramp_on ? ramp + 8'sh01 : 8'sh01;
    if (ramp_on)
    begin
      vt <= inj ? 8'sh7F : ramp;
      vc <= inj ? -8'sh01 : 8'sh00;
    end
    else
    begin
      vt <= dt;
      vc <= dc;
    end
  end

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      fails++;
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    check(n < 20, 32'h0000_0001, "apb answer");
  endtask : apb

  task automatic drive(input logic signed [7:0] t, input logic signed [7:0] c);
    dt <= t;
    dc <= c;
  endtask : drive

  task automatic wait_cap();
    int k;
    n0 = ncap;
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (ncap == n0 && k < 20);
    check(k < 20, 32'h0000_0001, "capture wait");
  endtask : wait_cap

  // Captures in sixteen cycles
  task automatic rate(input int per16);
    logic [15:0] s;
    tick(1);
    #1;
    s = ncap;
    tick(16);
    #1;
    check(ncap - s, per16, "update rate");
  endtask : rate

  // Older sample on second port, next pair continues the stream
  task automatic pairs(input int gap);
    wait_cap();
    a = cf.code;
    check(cf.code, CODE_W'(cs.code + gap), "pair order");
    wait_cap();
    check(cs.code, CODE_W'(a + gap), "pair stream");
  endtask : pairs

  task automatic results();
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  initial
  begin
    {rst_n, en, sel, psel, pen, pwr, ramp_on, inj} = '0;
    {pa, pb, ce} = 3'b111;
    {dt, dc} = '0;
    paddr = 8'h00;
    pwdata = WORD_ZERO;
    tick(2);
    rst_n <= 1'b1;
    // Reset values and an unmapped address
    apb(1'b0, OFS_MASK, WORD_ZERO);
    check(rd, WORD_ZERO, "mask reset");
    apb(1'b0, OFS_STATE, WORD_ZERO);
    check(rd & 32'h0000_0033, 32'h0000_0010, "state reset");
    apb(1'b0, OFS_CTRL, WORD_ZERO);
    check(rd, WORD_ZERO, "ctrl read");
    apb(1'b0, 8'h10, WORD_ZERO);
    check({rd[0], err}, 2'b01, "unmapped read");
    // Mode selection table
    for (int i = 0; i < 4; i++)
    begin
      tick(1);
      en <= i[1];
      sel <= i[0];
      tick(2);
      apb(1'b0, OFS_STATE, WORD_ZERO);
      check(rd & 32'h0000_0003, i[1] ? (i[0] ? 2 : 1) : 0, "mode");
    end
    tick(1);
    {en, sel} <= 2'b00;
    tick(2);
    apb(1'b1, OFS_STATUS, 32'h0000_0003);
    apb(1'b1, OFS_MASK, 32'h0000_0001);
    // Full rate: scale ends, midscale, repeat on second port
    tick(1);
    drive(-8'sh80, 8'sh00);
    tick(3);
    #1;
    check(p1, CODE_ZERO, "negative full scale");
    check(ovr, 1'b0, "negative overrange");
    check(p1_n, CODE_FULL, "complement lines");
    tick(1);
    drive(8'sh00, 8'sh00);
    tick(3);
    #1;
    a = p1;
    tick(1);
    #1;
    check(p1, a ^ 8'hFF, "midscale toggle");
    check(a == CODE_MID_LO || a == CODE_MID_HI, 1'b1, "midscale code");
    tick(1);
    drive(8'sh7F, -8'sh01);
    tick(1);
    drive(8'sh05, 8'sh00);
    tick(2);
    #1;
    check({p1, ovr, ovr_n, dr ^ dr_n}, {CODE_FULL, 3'b101}, "positive full scale");
    tick(1);
    #1;
    check({p1, p2, p2_n}, {8'h85, CODE_FULL, 8'h00}, "second port delay");
    check(ovr, 1'b0, "first port flag only");
    // Overrange event reaches the interrupt and clears
    tick(1);
    check(irq, 1'b1, "irq raised");
    apb(1'b1, OFS_STATUS, 32'h0000_0001);
    apb(1'b0, OFS_STATUS, WORD_ZERO);
    check(rd[0], 1'b0, "status cleared");
    check(irq, 1'b0, "irq cleared");
    // Second port power-down, either pin
    for (int i = 0; i < 2; i++)
    begin
      tick(1);
      pa <= i[0];
      pb <= !i[0];
      tick(3);
      #1;
      check({p2, p2_n}, 16'hFFFF, "powered down port");
    end
    tick(1);
    {pa, pb} <= 2'b11;
    // Half rate
    tick(1);
    {en, sel} <= 2'b10;
    ramp_on <= 1'b1;
    tick(8);
    rate(8);
    pairs(1);
    apb(1'b0, OFS_STATUS, WORD_ZERO);
    check(rd[1], 1'b1, "mode change event");
    check(irq, 1'b0, "masked event");
    tick(1);
    inj <= 1'b1;
    tick(1);
    inj <= 1'b0;
    hits = 0;
    repeat (3)
    begin
      wait_cap();
      check(cf.overrange, cf.code == CODE_FULL || cs.code == CODE_FULL, "shared flag");
      hits += int'(cf.overrange);
    end
    check(hits > 0, 1'b1, "flag seen");
    // Quarter rate
    tick(1);
    sel <= 1'b1;
    tick(8);
    rate(4);
    pairs(2);
    // Demux resync zeroes the phase, which then steps on once per sample
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    apb(1'b0, OFS_STATE, WORD_ZERO);
    check(rd[ST_PHASE_LSB +: 2], PHASE_RST, "resync phase");
    apb(1'b0, OFS_STATE, WORD_ZERO);
    check(rd[ST_PHASE_LSB +: 2], 2'h3, "phase after resync");
    // Clock enable low freezes the data-ready clock, so no captures
    ce <= 1'b0;
    rate(0);
    ce <= 1'b1;
    tick(1);
    ramp_on <= 1'b0;
    results();
  end
endmodule : adc_output_demux_tb_top
